// ---- pkg/lcs_params.svh ----
// offsets, field positions, reset values and timing counts of the setpoint control
`ifndef LCS_PARAMS_SVH
`define LCS_PARAMS_SVH

`define LCS_OFF_CTRL 8'h00
`define LCS_OFF_GAIN 8'h04
`define LCS_OFF_SP 8'h08
`define LCS_OFF_LIM 8'h0C
`define LCS_OFF_STAT 8'h10
`define LCS_OFF_ERR 8'h14
`define LCS_OFF_ADC 8'h18
`define LCS_OFF_TEMP 8'h1C

`define LCS_B_SOFT_EN 0
`define LCS_B_EXT_SP 1
`define LCS_B_EXT_EN 2
`define LCS_B_DEF_PWRON 3
`define LCS_B_ZERO_SCALE 7
`define LCS_CTRL_MASK 8'h8F

`define LCS_RST_CTRL 8'h04
`define LCS_RST_KP 16'h00C8
`define LCS_RST_KI 16'h0064
`define LCS_RST_SP 10'h000
`define LCS_RST_LIM 10'h384

`define LCS_MIN_CUR 10'h01E
`define LCS_MAX_CUR 10'h384
`define LCS_TEMP_LIMIT_C 8'h50

`define LCS_CLK_HZ 10000000
`define LCS_ST_TIMEOUT_S 15
`define LCS_PI_SHIFT 8

`endif

// ---- pkg/lcs_pkg.sv ----
// types shared by the setpoint control logic
package lcs_pkg;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] kp;
    logic [15:0] ki;
    logic [9:0] sp;
    logic [9:0] lim;
  } lcs_settings_s;

  typedef enum logic [2:0] {
    LCS_ST_TEST = 3'b001,
    LCS_ST_OK = 3'b010,
    LCS_ST_FAIL = 3'b100
  } lcs_state_e;

endpackage

// ---- logic/lcs_control.sv ----
// laser current setpoint control with pi regulator and axi4-lite registers
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "lcs_params.svh"

// Notes on behaviour
// [RQ1] pi loop, gains adjustable, defaults 200/100
// [RQ2] setpoints counted in 0.1 A steps
// [RQ3] effective setpoint clamped to limiter value
// [RQ4] source bit 1 writable only while disabled
// [RQ5] bit7 low: external spans min to max
// [RQ6] bit7 high: external spans zero to max
// [RQ7] zero scaling below minimum disables output
// [RQ8] external setpoint taken as 10-bit sample
// [RQ9] above 80 C: latch fault, shut down
// [RQ10] enable low then high clears fault
// [RQ11] self test at power-up gates enabling
// [RQ12] driver ok high after passed test
// [RQ13] self test ends by 15 s timeout
// [RQ14] pin enable: output only while high
// [RQ15] any error disables output, ok low
// [RQ16] settings restored or defaults at power-up
// [RQ17] attaching a control unit changes nothing
// [RQ18] handheld ignored while serial host attached
// [RQ19] operator alters setpoint after gain change
// [RQ20] enable source chosen by external-enable bit
// [RQ21] serial link 115200 8E1, outside block
// [RQ22] enable synchronised, edge clears fault
// [RQ23] disabled and ok low until test passes
module lcs_control
  import lcs_pkg::*;
#(
  parameter int ST_TIMEOUT_CYC = `LCS_ST_TIMEOUT_S * `LCS_CLK_HZ,
  parameter int ADC_W = 10,
  parameter int OUT_W = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  input wire logic en_pin_i,
  input wire logic [ADC_W-1:0] adc_data_i,
  input wire logic adc_valid_i,
  input wire logic [7:0] temp_c_i,
  input wire logic [9:0] meas_i,
  input wire logic st_done_i,
  input wire logic st_ok_i,
  input wire logic serial_link_i,
  input wire logic hh_wr_i,
  input wire logic [7:0] hh_addr_i,
  input wire logic [31:0] hh_wdata_i,
  input wire lcs_settings_s retained_i,
  input wire lcs_settings_s defaults_i,
  output lcs_settings_s settings_o,
  output logic [9:0] setpoint_o,
  output logic out_en_o,
  output logic [OUT_W-1:0] drive_o,
  output logic driver_ok_o
);

  lcs_settings_s cfg_q;
  lcs_settings_s cfg_d;
  lcs_state_e st_q;
  lcs_state_e st_d;
  logic load_q;
  logic [31:0] st_cnt_q;
  logic en_s1_q;
  logic en_s2_q;
  logic en_s3_q;
  logic ot_q;
  logic [ADC_W-1:0] adc_q;
  logic out_en_q;
  logic out_en_d;
  logic signed [31:0] iacc_q;
  logic [OUT_W-1:0] drive_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  // ---- register bus handshakes
  wire aw_hs = s_awvalid_i & s_wvalid_i & ~bvalid_q;
  wire ar_hs = s_arvalid_i & ~rvalid_q;
  assign s_awready_o = aw_hs;
  assign s_wready_o = aw_hs;
  assign s_arready_o = ~rvalid_q;
  assign s_bvalid_o = bvalid_q;
  assign s_bresp_o = bresp_q;
  assign s_rvalid_o = rvalid_q;
  assign s_rresp_o = rresp_q;
  assign s_rdata_o = rdata_q;

  // handheld writes drop out once the serial host owns the registers
  wire hh_go = hh_wr_i & ~serial_link_i & ~aw_hs; // RQ18
  wire wr_en = aw_hs | hh_go;
  wire [7:0] wr_addr = aw_hs ? s_awaddr_i : hh_addr_i;
  wire [31:0] wr_data = aw_hs ? s_wdata_i : hh_wdata_i;
  wire [3:0] wr_strb = aw_hs ? s_wstrb_i : 4'hF;
  logic [31:0] wr_mask;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mask
      assign wr_mask[gi*8 +: 8] = {8{wr_strb[gi]}};
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  wire w_ctrl = wr_en & (wr_addr == `LCS_OFF_CTRL);
  wire w_gain = wr_en & (wr_addr == `LCS_OFF_GAIN);
  wire w_sp = wr_en & (wr_addr == `LCS_OFF_SP);
  wire w_lim = wr_en & (wr_addr == `LCS_OFF_LIM);
  wire w_ro = (wr_addr == `LCS_OFF_STAT) | (wr_addr == `LCS_OFF_ERR) |
              (wr_addr == `LCS_OFF_ADC) | (wr_addr == `LCS_OFF_TEMP);
  wire w_bad = ~(w_ctrl | w_gain | w_sp | w_lim | w_ro);

  wire [31:0] m_ctrl = merge({24'h0, cfg_q.ctrl}, wr_data, wr_mask);
  wire [31:0] m_gain = merge({cfg_q.ki, cfg_q.kp}, wr_data, wr_mask);
  wire [31:0] m_sp = merge({22'h0, cfg_q.sp}, wr_data, wr_mask);
  wire [31:0] m_lim = merge({22'h0, cfg_q.lim}, wr_data, wr_mask);
  wire [7:0] ctrl_w = m_ctrl[7:0] & `LCS_CTRL_MASK;
  // the source select keeps its value while the output runs
  wire src_w = out_en_q ? cfg_q.ctrl[`LCS_B_EXT_SP] : ctrl_w[`LCS_B_EXT_SP]; // RQ4

  // settings next value; the first cycle after reset restores the stored set, or the defaults when its bit 3 is set
  always_comb begin
    cfg_d = cfg_q;
    if (load_q) begin
      if (retained_i.ctrl[`LCS_B_DEF_PWRON]) begin
        cfg_d = defaults_i; // RQ16
      end else begin
        cfg_d = retained_i; // RQ16
      end
      cfg_d.ctrl = cfg_d.ctrl & `LCS_CTRL_MASK;
    end else begin
      if (w_ctrl) begin
        cfg_d.ctrl = {ctrl_w[7:2], src_w, ctrl_w[0]}; // RQ4
      end
      if (w_gain) begin
        cfg_d.kp = m_gain[15:0]; // RQ1
        cfg_d.ki = m_gain[31:16]; // RQ1
      end
      if (w_sp) begin
        cfg_d.sp = m_sp[9:0]; // RQ2
      end
      if (w_lim) begin
        cfg_d.lim = m_lim[9:0]; // RQ3
      end
    end
  end

  // attaching a unit only opens a write path; no write happens by itself
  assign settings_o = cfg_q; // RQ17

  // ---- enable synchroniser and edge detect
  wire en_rise = en_s2_q & ~en_s3_q; // RQ22
  wire en_src = cfg_q.ctrl[`LCS_B_EXT_EN] ? en_s2_q : cfg_q.ctrl[`LCS_B_SOFT_EN]; // RQ20

  // ---- external setpoint scaling
  wire zero_mode = cfg_q.ctrl[`LCS_B_ZERO_SCALE];
  wire ext_sel = cfg_q.ctrl[`LCS_B_EXT_SP];
  // full scale code is treated as 1024 so both ends of the span are exact
  wire adc_top = &adc_q;
  wire [ADC_W:0] adc_x = adc_top ? (ADC_W+1)'(1 << ADC_W) : {1'b0, adc_q};
  wire [9:0] span = zero_mode ? `LCS_MAX_CUR : (`LCS_MAX_CUR - `LCS_MIN_CUR); // RQ5
  wire [9:0] base = zero_mode ? 10'h000 : `LCS_MIN_CUR; // RQ6
  wire [ADC_W+10:0] prod = adc_x * span;
  wire [9:0] ext_sp = base + prod[ADC_W+9:ADC_W]; // RQ8
  wire ext_low = ext_sel & zero_mode & (ext_sp < `LCS_MIN_CUR); // RQ7
  wire [9:0] raw_sp = ext_sel ? ext_sp : cfg_q.sp;
  wire [9:0] eff_sp = (raw_sp > cfg_q.lim) ? cfg_q.lim : raw_sp; // RQ3
  assign setpoint_o = eff_sp;

  // ---- overtemperature
  wire hot = temp_c_i > `LCS_TEMP_LIMIT_C; // RQ9

  // ---- self test sequence
  wire st_tmo = st_cnt_q >= 32'(ST_TIMEOUT_CYC - 1);
  always_comb begin
    st_d = st_q;
    case (st_q)
      LCS_ST_TEST: begin
        if (st_done_i & st_ok_i) begin
          st_d = LCS_ST_OK; // RQ11
        end else if (st_done_i | st_tmo) begin
          st_d = LCS_ST_FAIL; // RQ13
        end
      end
      LCS_ST_OK: st_d = LCS_ST_OK;
      LCS_ST_FAIL: st_d = LCS_ST_FAIL;
      default: st_d = LCS_ST_FAIL;
    endcase
  end

  wire passed = st_q == LCS_ST_OK;
  wire error_any = ot_q | (st_q == LCS_ST_FAIL); // RQ15
  assign out_en_d = passed & ~ot_q & ~hot & en_src & ~ext_low; // RQ14
  assign out_en_o = out_en_q;
  assign driver_ok_o = passed & ~ot_q; // RQ12

  // ---- pi regulator
  wire signed [11:0] err = $signed({2'b00, eff_sp}) - $signed({2'b00, meas_i});
  wire signed [28:0] p_term = $signed({1'b0, cfg_q.kp}) * err; // RQ1
  wire signed [28:0] i_step = $signed({1'b0, cfg_q.ki}) * err; // RQ1
  wire signed [32:0] i_sum = 33'(iacc_q) + 33'(i_step);
  wire i_ovf = i_sum[32] != i_sum[31];
  wire signed [31:0] i_next = i_ovf ? {i_sum[32], {31{~i_sum[32]}}} : i_sum[31:0];
  wire signed [32:0] pi_sum = 33'(p_term) + 33'(iacc_q);
  wire signed [32:0] pi_scl = pi_sum >>> `LCS_PI_SHIFT;
  wire pi_neg = pi_scl[32];
  wire pi_big = |pi_scl[31:OUT_W];
  wire [OUT_W-1:0] pi_out = pi_neg ? '0 : (pi_big ? '1 : pi_scl[OUT_W-1:0]);
  assign drive_o = drive_q;

  // ---- read decode
  wire [31:0] r_stat = {6'h00, eff_sp, 11'h000, serial_link_i, ext_low, passed,
                        out_en_q, driver_ok_o};
  wire [31:0] r_err = {30'h0, st_q == LCS_ST_FAIL, ot_q}; // RQ9
  wire r_hit = (s_araddr_i == `LCS_OFF_CTRL) | (s_araddr_i == `LCS_OFF_GAIN) |
               (s_araddr_i == `LCS_OFF_SP) | (s_araddr_i == `LCS_OFF_LIM) |
               (s_araddr_i == `LCS_OFF_STAT) | (s_araddr_i == `LCS_OFF_ERR) |
               (s_araddr_i == `LCS_OFF_ADC) | (s_araddr_i == `LCS_OFF_TEMP);
  logic [31:0] r_val;
  always_comb begin
    case (s_araddr_i)
      `LCS_OFF_CTRL: r_val = {24'h0, cfg_q.ctrl};
      `LCS_OFF_GAIN: r_val = {cfg_q.ki, cfg_q.kp};
      `LCS_OFF_SP: r_val = {22'h0, cfg_q.sp};
      `LCS_OFF_LIM: r_val = {22'h0, cfg_q.lim};
      `LCS_OFF_STAT: r_val = r_stat;
      `LCS_OFF_ERR: r_val = r_err;
      `LCS_OFF_ADC: r_val = {{(32-ADC_W){1'b0}}, adc_q};
      `LCS_OFF_TEMP: r_val = {24'h0, temp_c_i};
      default: r_val = 32'h0000_0000;
    endcase
  end

  // ---- settings and load
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cfg_q <= '{ctrl: `LCS_RST_CTRL, kp: `LCS_RST_KP, ki: `LCS_RST_KI,
                 sp: `LCS_RST_SP, lim: `LCS_RST_LIM}; // RQ1
      load_q <= 1'b1;
    end else begin
      cfg_q <= cfg_d;
      load_q <= 1'b0;
    end
  end

  // ---- self test state and timeout counter
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_q <= LCS_ST_TEST; // RQ23
      st_cnt_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      if (st_q == LCS_ST_TEST) begin
        st_cnt_q <= st_cnt_q + 32'h0000_0001; // RQ13
      end
    end
  end

  // ---- enable synchroniser
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      en_s3_q <= 1'b0;
    end else begin
      en_s1_q <= en_pin_i; // RQ22
      en_s2_q <= en_s1_q;
      en_s3_q <= en_s2_q;
    end
  end

  // ---- latched overtemperature, set wins over the clearing edge
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ot_q <= 1'b0;
    end else if (hot) begin
      ot_q <= 1'b1; // RQ9
    end else if (en_rise) begin
      ot_q <= 1'b0; // RQ10
    end
  end

  // ---- converter sample
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      adc_q <= '0;
    end else if (adc_valid_i) begin
      adc_q <= adc_data_i; // RQ8
    end
  end

  // ---- output stage enable and regulator state
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      out_en_q <= 1'b0; // RQ23
      iacc_q <= 32'sh0000_0000;
      drive_q <= '0;
    end else begin
      out_en_q <= out_en_d & ~error_any; // RQ15
      if (out_en_q) begin
        iacc_q <= i_next; // RQ1
        drive_q <= pi_out;
      end else begin
        iacc_q <= 32'sh0000_0000;
        drive_q <= '0;
      end
    end
  end

  // ---- bus write response
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
    end else if (aw_hs) begin
      bvalid_q <= 1'b1;
      bresp_q <= w_bad ? 2'b10 : 2'b00;
    end else if (s_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---- bus read response
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rvalid_q <= 1'b0;
      rresp_q <= 2'b00;
      rdata_q <= 32'h0000_0000;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rresp_q <= r_hit ? 2'b00 : 2'b10;
      rdata_q <= r_val;
    end else if (s_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// ---- sim/lcs_control_sva.sv ----
// assertion checker on the setpoint control ports
`timescale 1ns/1ps
module lcs_control_sva
  import lcs_pkg::*;
#(
  parameter int OUT_W = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  input wire logic [1:0] s_bresp_o,
  input wire logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic s_arvalid_i,
  input wire logic [31:0] s_rdata_o,
  input wire logic s_rvalid_o,
  input wire logic s_rready_i,
  input wire logic en_pin_i,
  input wire logic [7:0] temp_c_i,
  input wire lcs_settings_s settings_o,
  input wire logic [9:0] setpoint_o,
  input wire logic out_en_o,
  input wire logic [OUT_W-1:0] drive_o,
  input wire logic driver_ok_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire wr_take = s_awvalid_i && s_wvalid_i && !s_bvalid_o;
  wire ctrl_wr = wr_take && s_awaddr_i == 8'h00 && s_wstrb_i[0];
  a_write_answer: assert property (wr_take |=> s_bvalid_o)
    else $error("write taken without response");
  a_bresp_holds: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o))
    else $error("write response dropped early");
  a_read_answer: assert property (s_arvalid_i && !s_rvalid_o |=> s_rvalid_o)
    else $error("read taken without response");
  a_rdata_holds: assert property (s_rvalid_o && !s_rready_i |=> $stable(s_rdata_o))
    else $error("read data changed while waiting");
  a_out_needs_ok: assert property (out_en_o |-> driver_ok_o)
    else $error("output on without driver ok");
  a_hot_shutdown: assert property (temp_c_i > 8'h50 |=> !out_en_o && !driver_ok_o)
    else $error("overtemperature did not shut down");
  a_limit_clamp: assert property (setpoint_o <= settings_o.lim)
    else $error("setpoint above limiter");
  a_idle_no_drive: assert property (!out_en_o ##1 !out_en_o |-> drive_o == '0)
    else $error("regulator drives while disabled");
  a_src_locked: assert property (ctrl_wr && out_en_o |=> $stable(settings_o.ctrl[1]))
    else $error("source changed while enabled");
  a_pin_off: assert property ((settings_o.ctrl[2] && !en_pin_i) [*3] |=> !out_en_o)
    else $error("output on with enable pin low");
  c_write: cover property (wr_take);
  c_hot: cover property (temp_c_i > 8'h50 && driver_ok_o);
  c_zero_ext: cover property (settings_o.ctrl[7] && settings_o.ctrl[1] && out_en_o);
endmodule

bind lcs_control lcs_control_sva #(.OUT_W(OUT_W)) u_sva (
  .clk_i, .nrst_i, .s_awaddr_i, .s_awvalid_i, .s_wstrb_i, .s_wvalid_i, .s_bresp_o,
  .s_bvalid_o, .s_bready_i, .s_arvalid_i, .s_rdata_o, .s_rvalid_o, .s_rready_i,
  .en_pin_i, .temp_c_i, .settings_o, .setpoint_o, .out_en_o, .drive_o, .driver_ok_o
);

// ---- sim/lcs_ctl_model.sv ----
// external controller: enable pin and sampled setpoint converter
`timescale 1ns/1ps
module lcs_ctl_model (
  input wire logic clk_i,
  input wire logic want_en_i,
  input wire logic [9:0] level_i,
  output logic en_pin_o,
  output logic [9:0] adc_data_o,
  output logic adc_valid_o
);
  logic [1:0] cnt_q = 2'h0;
  initial begin
    en_pin_o = 1'b0;
    adc_data_o = 10'h000;
    adc_valid_o = 1'b0;
  end
  always @(posedge clk_i) begin
    en_pin_o <= want_en_i;
    cnt_q <= cnt_q + 2'h1;
    adc_valid_o <= (cnt_q == 2'h3);
    // between samples the data lines carry no valid code
    adc_data_o <= (cnt_q == 2'h3) ? level_i : ~adc_data_o;
  end
endmodule

// ---- sim/tb_lcs_control.sv ----
// self-checking bench for the setpoint control
`timescale 1ns/1ps
module tb_lcs_control;
  import lcs_pkg::*;
  logic clk_i = 1'b0, nrst_i = 1'b0, s_awvalid_i = 1'b0, s_wvalid_i = 1'b0;
  logic s_bready_i = 1'b0, s_arvalid_i = 1'b0, s_rready_i = 1'b0, st_done_i = 1'b0;
  logic st_ok_i = 1'b0, serial_link_i = 1'b0, hh_wr_i = 1'b0, want_en = 1'b0;
  logic [7:0] s_awaddr_i = 8'h00, s_araddr_i = 8'h00, temp_c_i = 8'h19, hh_addr_i = 8'h08;
  logic [31:0] s_wdata_i = 32'h0, hh_wdata_i = 32'h7, rd;
  logic [3:0] s_wstrb_i = 4'hF;
  logic [9:0] meas_i = 10'h000, level = 10'h000;
  logic [1:0] rsp;
  lcs_settings_s retained_i = '{8'h04, 16'h00C8, 16'h0064, 10'h000, 10'h384};
  lcs_settings_s defaults_i = '0;
  wire s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, en_pin_i, adc_valid_i;
  wire out_en_o, driver_ok_o;
  wire [15:0] drive_o;
  wire [1:0] s_bresp_o, s_rresp_o;
  wire [31:0] s_rdata_o;
  wire [9:0] adc_data_i, setpoint_o;
  wire lcs_settings_s settings_o;
  int err_count = 0, checks_done = 0;
  lcs_ctl_model u_ctl (.clk_i, .want_en_i(want_en), .level_i(level), .en_pin_o(en_pin_i),
    .adc_data_o(adc_data_i), .adc_valid_o(adc_valid_i));
  lcs_control #(.ST_TIMEOUT_CYC(200)) u_dut (.clk_i, .nrst_i, .s_awaddr_i, .s_awvalid_i,
    .s_awready_o, .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o,
    .s_bready_i, .s_araddr_i, .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o,
    .s_rvalid_o, .s_rready_i, .en_pin_i, .adc_data_i, .adc_valid_i, .temp_c_i, .meas_i,
    .st_done_i, .st_ok_i, .serial_link_i, .hh_wr_i, .hh_addr_i, .hh_wdata_i, .retained_i,
    .defaults_i, .settings_o, .setpoint_o, .out_en_o, .drive_o, .driver_ok_o);
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_awaddr_i <= a;
    s_wdata_i <= d;
    s_awvalid_i <= 1'b1;
    s_wvalid_i <= 1'b1;
    s_bready_i <= 1'b1;
    do @(posedge clk_i); while (!s_awready_o);
    s_awvalid_i <= 1'b0;
    s_wvalid_i <= 1'b0;
    do @(posedge clk_i); while (!s_bvalid_o);
    s_bready_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i <= 1'b1;
    do @(posedge clk_i); while (!s_arready_o);
    s_arvalid_i <= 1'b0;
    do @(posedge clk_i); while (!s_rvalid_o);
    rd = s_rdata_o;
    rsp = s_rresp_o;
    s_rready_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_power_up();
    chk("ok before test", driver_ok_o, 1'b0);
    chk("out before test", out_en_o, 1'b0);
    st_done_i <= 1'b1;
    st_ok_i <= 1'b1;
    cyc(2);
    chk("ok after test", driver_ok_o, 1'b1);
    rd_reg(8'h04);
    chk("gains", rd, 32'h006400C8);
    rd_reg(8'h20);
    chk("unmapped", {30'h0, rsp}, 32'h2);
  endtask
  task automatic t_setpoint();
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h00640190);
    rd_reg(8'h04);
    chk("new gains", rd, 32'h00640190);
    wr(8'h08, 32'h0FA);
    cyc(2);
    chk("internal sp", setpoint_o, 32'h0FA);
    wr(8'h0C, 32'h064);
    cyc(2);
    chk("clamped sp", setpoint_o, 32'h064);
    wr(8'h0C, 32'h384);
  endtask
  task automatic t_source_lock();
    wr(8'h00, 32'h01);
    cyc(2);
    chk("soft enable", out_en_o, 1'b1);
    wr(8'h00, 32'h03);
    rd_reg(8'h00);
    chk("source locked", rd, 32'h01);
    wr(8'h00, 32'h00);
    wr(8'h00, 32'h02);
    rd_reg(8'h00);
    chk("source free", rd, 32'h02);
  endtask
  task automatic t_scaling();
    logic [9:0] cd [4] = '{10'h200, 10'h200, 10'h3FF, 10'h000};
    logic md [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    int n;
    for (int i = 0; i < 4; i++) begin
      level <= cd[i];
      wr(8'h00, {24'h0, md[i], 7'h02});
      cyc(12);
      n = (cd[i] == 10'h3FF) ? 1024 : int'(cd[i]);
      chk("ext sp", setpoint_o, md[i] ? (n * 900) >> 10 : 30 + ((n * 870) >> 10));
    end
    level <= 10'h200;
    wr(8'h00, 32'h83);
    cyc(12);
    chk("zero scale on", out_en_o, 1'b1);
    level <= 10'h014;
    cyc(12);
    chk("below min off", out_en_o, 1'b0);
  endtask
  task automatic t_overtemp();
    wr(8'h00, 32'h04);
    want_en <= 1'b1;
    cyc(6);
    chk("pin enable", out_en_o, 1'b1);
    chk("drive on", {31'h0, drive_o != 16'h0000}, 32'h1);
    temp_c_i <= 8'h51;
    cyc(2);
    chk("hot out", out_en_o, 1'b0);
    chk("hot ok", driver_ok_o, 1'b0);
    temp_c_i <= 8'h50;
    cyc(4);
    chk("latched", out_en_o, 1'b0);
    chk("drive off", drive_o, 32'h0);
    rd_reg(8'h14);
    chk("error bit", rd, 32'h1);
    want_en <= 1'b0;
    cyc(4);
    want_en <= 1'b1;
    cyc(8);
    chk("re-enabled", out_en_o, 1'b1);
    chk("ok again", driver_ok_o, 1'b1);
  endtask
  task automatic t_handheld();
    for (int s = 1; s >= 0; s--) begin
      serial_link_i <= s[0];
      hh_wr_i <= 1'b1;
      cyc(1);
      hh_wr_i <= 1'b0;
      cyc(1);
      rd_reg(8'h08);
      chk("handheld", rd, s ? 32'h0FA : 32'h007);
    end
  endtask
  task automatic t_timeout();
    st_done_i <= 1'b0;
    nrst_i <= 1'b0;
    cyc(2);
    nrst_i <= 1'b1;
    cyc(205);
    st_done_i <= 1'b1;
    cyc(2);
    chk("test timeout ok", driver_ok_o, 1'b0);
    chk("test timeout out", out_en_o, 1'b0);
    rd_reg(8'h14);
    chk("test fail bit", rd, 32'h2);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    // the whole sequence needs well under a thousand cycles
    #2000000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    cyc(3);
    t_power_up();
    t_setpoint();
    t_source_lock();
    t_scaling();
    t_overtemp();
    t_handheld();
    t_timeout();
    test_done();
  end
endmodule
